// [verilog/ctbf_core.sv]
// Transmit buffer scheduling, cancellation and receive ID filter behind AXI4-Lite
module ctbf_core
  import ctbf_pkg::*;
(
  // Clock and reset
  input  wire logic              sys_clk,
  input  wire logic              reset,
  // AXI4-Lite slave
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic [2:0]        s_axi_awprot,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  output logic [1:0]             s_axi_bresp,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic [2:0]        s_axi_arprot,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  // Protocol controller, transmit side
  output logic                   tx_valid,
  output ctbf_txf_t              tx_frame,
  input  wire logic              pc_sof,
  input  wire logic              pc_ok,
  input  wire logic              pc_fail,
  // Protocol controller, receive side
  input  ctbf_rx_t               rx_in,
  output logic                   rx_store,
  output logic                   rx_fifo
);

  // ==========================================================
  // State
  ctbf_state_t s_r;   // Whole state of the block
  ctbf_state_t s_nxt; // Its next value

  // Register decode, shared by read and write paths
  function automatic ctbf_reg_t ctbf_dec(input logic [ADDR_W-1:0] a);
    if (a[1:0] != 2'h0) return RG_NONE;           // Unaligned
    if (a[7:4] == OFS_ID0[7:4]) return RG_ID;
    if (a[7:4] == OFS_DAT0[7:4]) return RG_DAT;
    case (a)
      OFS_CTRL: return RG_CTRL;
      OFS_SFLT: return RG_SFLT;
      OFS_EFA:  return RG_EFA;
      OFS_EFB:  return RG_EFB;
      OFS_ADD:  return RG_ADD;
      OFS_CAN:  return RG_CAN;
      OFS_OCC:  return RG_OCC;
      OFS_CFIN: return RG_CFIN;
      OFS_STAT: return RG_STAT;
      default:  return RG_NONE;
    endcase
  endfunction

  // Byte-lane merge of a write into an old value
  function automatic logic [31:0] ctbf_merge(input logic [31:0] o, input logic [31:0] d,
                                             input logic [3:0] st);
    logic [31:0] r;
    r = o;
    for (int i = 0; i < 4; i++) if (st[i]) r[8*i +: 8] = d[8*i +: 8];
    return r;
  endfunction

  // Lowest ID wins; ascending scan with strict compare keeps lowest number on ties
  function automatic logic [2:0] ctbf_pick(input logic [NBUF-1:0] av,
                                           input logic [NBUF-1:0][EID_W-1:0] ids);
    logic       f;
    logic [1:0] b;
    f = 1'b0;
    b = 2'h0;
    for (int i = 0; i < NBUF; i++) begin
      if (av[i] && (!f || ids[i] < ids[b])) begin
        f = 1'b1;
        b = i[1:0];
      end
    end
    return {f, b};
  endfunction

  // Filter compare; classic treats second field as mask, else dual exact IDs
  function automatic logic ctbf_match(input logic [EID_W-1:0] id, input logic [EID_W-1:0] f,
                                      input logic [EID_W-1:0] m, input logic [1:0] t);
    if (t == FT_CLASSIC) return ((id ^ f) & m) == '0;
    return (id == f) || (id == m);
  endfunction

  // Combinational helpers
  ctbf_reg_t            wsel;    // Decoded write target
  ctbf_reg_t            rsel;    // Decoded read target
  logic                 wr;      // Write commits this cycle
  logic [31:0]          wv;      // Write data under strobes
  logic [2:0]           pick;    // {found, buffer}
  logic                 begun_now;
  logic                 f_en, f_hit, f_store, f_fifo, f_prio;
  logic [2:0]           f_cfg;
  logic [1:0]           f_anf;
  logic [EID_W-1:0]     f_id, f_f, f_m;

  // ==========================================================
  // Next-state logic
  always_comb begin
    s_nxt = s_r;
    wsel  = ctbf_dec(s_r.aw_addr);
    rsel  = ctbf_dec(s_axi_araddr);
    wv    = ctbf_merge(32'h0, s_r.w_data, s_r.w_strb);
    // Address and data are taken in either order
    if (s_axi_awvalid && s_r.aw_rdy) begin
      s_nxt.aw_hold = 1'b1;
      s_nxt.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_r.w_rdy) begin
      s_nxt.w_hold = 1'b1;
      s_nxt.w_data = s_axi_wdata;
      s_nxt.w_strb = s_axi_wstrb;
    end
    if (s_r.bvalid && s_axi_bready) s_nxt.bvalid = 1'b0;
    wr = s_r.aw_hold && s_r.w_hold && !s_r.bvalid;
    if (wr) begin
      s_nxt.aw_hold = 1'b0;
      s_nxt.w_hold  = 1'b0;
      s_nxt.bvalid  = 1'b1;
      s_nxt.bresp   = (wsel == RG_NONE) ? RESP_SLVERR : RESP_OKAY;
      case (wsel)
        RG_CTRL: s_nxt.ctrl = ctbf_merge({25'h0, s_r.ctrl}, s_r.w_data,
                                         s_r.w_strb)[CTRL_W-1:0];
        RG_SFLT: s_nxt.sflt = ctbf_merge(s_r.sflt, s_r.w_data, s_r.w_strb);
        RG_EFA:  s_nxt.efa  = ctbf_merge(s_r.efa, s_r.w_data, s_r.w_strb);
        RG_EFB:  s_nxt.efb  = ctbf_merge(s_r.efb, s_r.w_data, s_r.w_strb);
        RG_ID:   s_nxt.tx_id[s_r.aw_addr[3:2]] = wv[EID_W-1:0];
        // Payload writes reach the buffer only; the offered frame keeps its copy
        RG_DAT:  s_nxt.tx_data[s_r.aw_addr[3:2]] = ctbf_merge(
                   s_r.tx_data[s_r.aw_addr[3:2]], s_r.w_data, s_r.w_strb);
        RG_ADD: begin
          // Every set bit is requested in the same cycle
          s_nxt.pend = s_r.pend | wv[NBUF-1:0];
          s_nxt.occ  = s_r.occ & ~wv[NBUF-1:0];
          s_nxt.cfin = s_r.cfin & ~wv[NBUF-1:0];
        end
        RG_CAN:  s_nxt.creq = s_r.creq | (wv[NBUF-1:0] & s_r.pend);
        RG_STAT: if (wv[STAT_HPM]) s_nxt.hpm = 1'b0; // Write one to clear
        default: ;
      endcase
    end
    s_nxt.aw_rdy = !s_nxt.aw_hold && !s_nxt.bvalid;
    s_nxt.w_rdy  = !s_nxt.w_hold && !s_nxt.bvalid;

    // Read channel, answered one cycle after the address is taken
    if (s_r.rvalid && s_axi_rready) s_nxt.rvalid = 1'b0;
    if (s_axi_arvalid && s_r.ar_rdy) begin
      s_nxt.rvalid = 1'b1;
      s_nxt.rresp  = (rsel == RG_NONE) ? RESP_SLVERR : RESP_OKAY;
      case (rsel)
        RG_CTRL: s_nxt.rdata = {25'h0, s_r.ctrl};
        RG_SFLT: s_nxt.rdata = s_r.sflt;
        RG_EFA:  s_nxt.rdata = s_r.efa;
        RG_EFB:  s_nxt.rdata = s_r.efb;
        RG_ADD:  s_nxt.rdata = {28'h0, s_r.pend};
        RG_CAN:  s_nxt.rdata = {28'h0, s_r.creq};
        RG_OCC:  s_nxt.rdata = {28'h0, s_r.occ};
        RG_CFIN: s_nxt.rdata = {28'h0, s_r.cfin};
        RG_STAT: s_nxt.rdata = {22'h0, s_r.put_idx, 3'h0, s_r.st != TX_IDLE, 3'h0, s_r.hpm};
        RG_ID:   s_nxt.rdata = {3'h0, s_r.tx_id[s_axi_araddr[3:2]]};
        RG_DAT:  s_nxt.rdata = s_r.tx_data[s_axi_araddr[3:2]];
        default: s_nxt.rdata = 32'h0;
      endcase
    end
    s_nxt.ar_rdy = !s_nxt.rvalid;

    // Cancellation: once the frame has begun it runs to its end
    begun_now = s_r.begun || (pc_sof && s_r.tx_valid);
    for (int i = 0; i < NBUF; i++) begin
      if (s_nxt.creq[i] && !(begun_now && s_r.st == TX_ACTIVE && s_r.act == i[1:0])) begin
        s_nxt.pend[i] = 1'b0;
        s_nxt.cfin[i] = 1'b1;
        s_nxt.creq[i] = 1'b0;
        if (s_r.st == TX_ACTIVE && s_r.act == i[1:0]) begin
          s_nxt.tx_valid = 1'b0;                 // Withdrawn before start of frame
          s_nxt.st       = TX_RETIRE;
        end
      end
    end

    // Transmit sequencer
    pick = ctbf_pick(s_r.pend & ~s_r.creq, s_r.tx_id);
    case (s_r.st)
      TX_IDLE: begin
        if (pick[2]) begin
          s_nxt.act      = pick[1:0];
          s_nxt.tx_valid = 1'b1;
          s_nxt.begun    = 1'b0;
          // Snapshot decouples the bus frame from later buffer writes
          s_nxt.txf      = '{id: s_r.tx_id[pick[1:0]], data: s_r.tx_data[pick[1:0]],
                             bufn: pick[1:0]};
          s_nxt.st       = TX_ACTIVE;
        end
      end
      TX_ACTIVE: begin
        if (pc_sof) s_nxt.begun = 1'b1;
        if (pc_ok) begin
          // A cancel that came too late leaves no finished mark
          s_nxt.pend[s_r.act] = 1'b0;
          s_nxt.occ[s_r.act]  = 1'b1;
          s_nxt.creq[s_r.act] = 1'b0;
          s_nxt.tx_valid      = 1'b0;
          s_nxt.st            = TX_RETIRE;
        end else if (pc_fail) begin
          if (s_r.ctrl[CTRL_DAR] || s_nxt.creq[s_r.act]) begin
            s_nxt.pend[s_r.act] = 1'b0;
            s_nxt.cfin[s_r.act] = 1'b1;
            s_nxt.creq[s_r.act] = 1'b0;
          end
          // Otherwise pending stays set and the buffer competes again
          s_nxt.tx_valid = 1'b0;
          s_nxt.st       = TX_RETIRE;
        end
      end
      TX_RETIRE: s_nxt.st = TX_IDLE;             // One cycle for flags to settle
      default:   s_nxt.st = TX_IDLE;
    endcase

    // Put index: lowest free queue buffer, or the last one when all are full
    s_nxt.put_idx = 2'(NBUF - 1);
    for (int i = NBUF - 1; i >= NDED; i--) begin
      if (!s_nxt.pend[i]) s_nxt.put_idx = i[1:0];
    end

    // Receive acceptance filter
    if (rx_in.ext) begin
      f_en  = s_r.ctrl[CTRL_EEN];
      f_cfg = s_r.efa[FLT_ECFG +: 3];
      f_f   = s_r.efa[EID_W-1:0];
      f_m   = s_r.efb[EID_W-1:0];
      f_anf = s_r.ctrl[CTRL_ANFE +: 2];
      f_id  = rx_in.id;
      f_hit = ctbf_match(f_id, f_f, f_m, s_r.efb[FLT_TYPE +: 2]);
    end else begin
      f_en  = s_r.ctrl[CTRL_SEN];
      f_cfg = s_r.sflt[FLT_SCFG +: 3];
      f_f   = {18'h0, s_r.sflt[SID_W-1:0]};
      f_m   = {18'h0, s_r.sflt[FLT_ID2 +: SID_W]};
      f_anf = s_r.ctrl[CTRL_ANFS +: 2];
      f_id  = {18'h0, rx_in.id[SID_W-1:0]};
      f_hit = ctbf_match(f_id, f_f, f_m, s_r.sflt[FLT_TYPE +: 2]);
    end
    f_hit = f_hit && f_en && (f_cfg != 3'h0);
    if (f_hit) begin
      f_store = f_cfg[0] ^ f_cfg[1];
      f_fifo  = f_cfg[1];
      f_prio  = f_cfg[2] && (f_cfg[1:0] != 2'h3);
    end else begin
      // Global rule for unmatched frames never marks priority
      f_store = !f_anf[1];
      f_fifo  = f_anf[0];
      f_prio  = 1'b0;
    end
    s_nxt.rx_store = rx_in.valid && f_store;
    s_nxt.rx_fifo  = f_fifo;
    if (rx_in.valid && f_prio) s_nxt.hpm = 1'b1; // set wins over clear
  end

  // ==========================================================
  // State register
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      s_r         <= '0;
      s_r.ctrl    <= CTRL_RST;
      s_r.st      <= TX_IDLE;
      s_r.put_idx <= 2'(NDED);
    end else begin
      s_r <= s_nxt;
    end
  end

  // Outputs straight from the state register
  assign s_axi_awready = s_r.aw_rdy;
  assign s_axi_wready  = s_r.w_rdy;
  assign s_axi_bvalid  = s_r.bvalid;
  assign s_axi_bresp   = s_r.bresp;
  assign s_axi_arready = s_r.ar_rdy;
  assign s_axi_rvalid  = s_r.rvalid;
  assign s_axi_rdata   = s_r.rdata;
  assign s_axi_rresp   = s_r.rresp;
  assign tx_valid      = s_r.tx_valid;
  assign tx_frame      = s_r.txf;
  assign rx_store      = s_r.rx_store;
  assign rx_fifo       = s_r.rx_fifo;

  // ==========================================================
  // Assertions
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);

  property p_occ_set;
    (s_r.st == TX_ACTIVE && pc_ok) |=> s_r.occ[$past(s_r.act)] && !s_r.pend[$past(s_r.act)];
  endproperty
  a_occ_set: assert property (p_occ_set) else $error("occurred flag not set");

  property p_dar_fail;
    (s_r.st == TX_ACTIVE && pc_fail && !pc_ok && s_r.ctrl[CTRL_DAR])
      |=> s_r.cfin[$past(s_r.act)] && !s_r.pend[$past(s_r.act)];
  endproperty
  a_dar_fail: assert property (p_dar_fail) else $error("failure not cancelled");

  property p_retry;
    (s_r.st == TX_ACTIVE && s_r.begun && pc_fail && !pc_ok && !s_r.ctrl[CTRL_DAR]
      && !s_r.creq[s_r.act] && !(wr && wsel == RG_CAN)) |=> s_r.pend[$past(s_r.act)];
  endproperty
  a_retry: assert property (p_retry) else $error("retransmit dropped");

  property p_late_cancel;
    (s_r.st == TX_ACTIVE && s_r.begun && s_r.creq[s_r.act] && !pc_ok && !pc_fail)
      |=> s_r.tx_valid && !s_r.cfin[$past(s_r.act)] && s_r.pend[$past(s_r.act)];
  endproperty
  a_late_cancel: assert property (p_late_cancel) else $error("begun frame cancelled");

  property p_frame_stable;
    (s_r.tx_valid && $past(s_r.tx_valid)) |-> $stable(s_r.txf);
  endproperty
  a_frame_stable: assert property (p_frame_stable) else $error("frame changed");

  property p_no_global_hpm;
    (rx_in.valid && !f_hit && !s_r.hpm) |=> !s_r.hpm;
  endproperty
  a_no_global_hpm: assert property (p_no_global_hpm) else $error("hpm from global");

  property p_std_global;
    (rx_in.valid && !rx_in.ext && !s_r.ctrl[CTRL_SEN] && !s_r.ctrl[CTRL_ANFS+1])
      |=> s_r.rx_store && (s_r.rx_fifo == $past(s_r.ctrl[CTRL_ANFS]));
  endproperty
  a_std_global: assert property (p_std_global) else $error("std frame lost");

  property p_ext_global;
    (rx_in.valid && rx_in.ext && !s_r.ctrl[CTRL_EEN] && !s_r.ctrl[CTRL_ANFE+1])
      |=> s_r.rx_store && (s_r.rx_fifo == $past(s_r.ctrl[CTRL_ANFE]));
  endproperty
  a_ext_global: assert property (p_ext_global) else $error("ext frame lost");

  property p_put_idx;
    (s_r.pend[NBUF-1:NDED] != '1) |-> !s_r.pend[s_r.put_idx] && s_r.put_idx >= 2'(NDED);
  endproperty
  a_put_idx: assert property (p_put_idx) else $error("put index not free");

endmodule // ctbf_core

// [verilog/ctbf_pkg.sv]
// Package: constants, field layout and types for the CAN transmit buffer and ID filter block
package ctbf_pkg;
  // ==========================================================
  // Sizes
  localparam int NBUF   = 4;  // Transmit buffers in total
  localparam int NDED   = 2;  // Buffers 0..NDED-1 dedicated, the rest form the queue
  localparam int ADDR_W = 8;  // AXI byte address width
  localparam int EID_W  = 29; // Extended identifier width
  localparam int SID_W  = 11; // Standard identifier width
  // ==========================================================
  // Register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00; // Control and global filter
  localparam logic [7:0] OFS_SFLT = 8'h04; // Standard filter element
  localparam logic [7:0] OFS_EFA  = 8'h08; // Extended filter element, word 0
  localparam logic [7:0] OFS_EFB  = 8'h0c; // Extended filter element, word 1
  localparam logic [7:0] OFS_ADD  = 8'h10; // Add request (W) / pending (R)
  localparam logic [7:0] OFS_CAN  = 8'h14; // Cancel request
  localparam logic [7:0] OFS_OCC  = 8'h18; // Transmission occurred
  localparam logic [7:0] OFS_CFIN = 8'h1c; // Cancellation finished
  localparam logic [7:0] OFS_STAT = 8'h20; // Status
  localparam logic [7:0] OFS_ID0  = 8'h40; // Buffer identifiers, one word each
  localparam logic [7:0] OFS_DAT0 = 8'h50; // Buffer payload words, one each
  // ==========================================================
  // Field positions
  localparam int CTRL_DAR   = 0; // disable_auto_retransmit
  localparam int CTRL_ANFS  = 1; // accept_nonmatching_standard [2:1]
  localparam int CTRL_ANFE  = 3; // accept_nonmatching_extended [4:3]
  localparam int CTRL_SEN   = 5; // Standard element configured
  localparam int CTRL_EEN   = 6; // Extended element configured
  localparam int CTRL_W     = 7;
  localparam int FLT_ID2    = 16; // std_filter_id_second position
  localparam int FLT_SCFG   = 27; // std_filter_element_config [29:27]
  localparam int FLT_ECFG   = 29; // ext_filter_element_config [31:29]
  localparam int FLT_TYPE   = 30; // Filter type [31:30]
  localparam int STAT_HPM   = 0;  // high_priority_message_flag
  localparam int STAT_BUSY  = 4;
  localparam int STAT_PUT   = 8;  // Put index [9:8]
  // ==========================================================
  // Reset values and encodings
  localparam logic [CTRL_W-1:0] CTRL_RST    = 7'h00;
  localparam logic [1:0]        FT_CLASSIC  = 2'h2;
  localparam logic [1:0]        RESP_OKAY   = 2'h0;
  localparam logic [1:0]        RESP_SLVERR = 2'h2;
  // ==========================================================
  // Types
  typedef enum logic [1:0] {
    TX_IDLE   = 2'h0,
    TX_ACTIVE = 2'h1,
    TX_RETIRE = 2'h3
  } ctbf_txst_t;

  typedef enum logic [3:0] {
    RG_CTRL, RG_SFLT, RG_EFA, RG_EFB, RG_ADD, RG_CAN, RG_OCC, RG_CFIN,
    RG_STAT, RG_ID, RG_DAT, RG_NONE
  } ctbf_reg_t;

  typedef struct packed {
    logic             valid;
    logic             ext;   // Extended identifier
    logic [EID_W-1:0] id;    // Standard IDs in low bits
  } ctbf_rx_t;

  typedef struct packed {
    logic [EID_W-1:0] id;
    logic [31:0]      data;
    logic [1:0]       bufn;
  } ctbf_txf_t;

  typedef struct packed {
    logic                            aw_rdy, w_rdy, aw_hold, w_hold;
    logic [ADDR_W-1:0]               aw_addr;
    logic [31:0]                     w_data;
    logic [3:0]                      w_strb;
    logic                            bvalid;
    logic [1:0]                      bresp;
    logic                            ar_rdy, rvalid;
    logic [1:0]                      rresp;
    logic [31:0]                     rdata;
    logic [CTRL_W-1:0]               ctrl;
    logic [31:0]                     sflt, efa, efb;
    logic [NBUF-1:0][EID_W-1:0]      tx_id;
    logic [NBUF-1:0][31:0]           tx_data;
    logic [NBUF-1:0]                 pend, occ, cfin, creq;
    logic                            hpm;
    logic [1:0]                      put_idx;
    ctbf_txst_t                      st;
    logic [1:0]                      act;
    logic                            begun;
    logic                            tx_valid;
    ctbf_txf_t                       txf;
    logic                            rx_store, rx_fifo;
  } ctbf_state_t;
endpackage

// [sim/ctbf_bus_model.sv]
// Far-side model: protocol controller and bus answering offered frames
module ctbf_bus_model (
  // Clock and reset
  input  wire logic       sys_clk,
  input  wire logic       reset,
  // Offer from the block and test controls
  input  wire logic       tx_valid,
  input  wire logic       fail_all,
  input  wire logic [7:0] lat,
  // Start-of-frame and outcome pulses
  output logic            pc_sof,
  output logic            pc_ok,
  output logic            pc_fail
);
  // ==========================================================
  // Frame sequencing
  logic [1:0] ph_r;  // 0 idle, 1 on bus, 2 cool-down
  logic [7:0] cnt_r; // Bit times left in the frame
  // One frame at a time; cool-down lets the offer drop after an outcome
  always_ff @(posedge sys_clk) begin
    pc_sof  <= 1'b0;
    pc_ok   <= 1'b0;
    pc_fail <= 1'b0;
    if (reset) begin
      ph_r  <= 2'h0;
      cnt_r <= 8'h00;
    end else if (ph_r == 2'h0 && tx_valid) begin
      pc_sof <= 1'b1;
      ph_r   <= 2'h1;
      cnt_r  <= lat;
    end else if (ph_r == 2'h1 && cnt_r == 8'h00) begin
      pc_ok   <= !fail_all;
      pc_fail <= fail_all;
      ph_r    <= 2'h2;
    end else if (ph_r == 2'h1) begin
      cnt_r <= cnt_r - 8'h01;
    end else begin
      ph_r <= 2'h0;
    end
  end
endmodule // ctbf_bus_model

// [sim/test_can_tx_buffer_and_id_filter.sv]
// Self-checking bench for the transmit buffer and ID filter block
module test_can_tx_buffer_and_id_filter
  import ctbf_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  // ==========================================================
  // Signals
  logic              sys_clk = 1'b0, reset = 1'b1, pv = 1'b0, fail_all = 1'b0;
  logic              s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic              s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [ADDR_W-1:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [31:0]       s_axi_wdata = '0, s_axi_rdata;
  logic [1:0]        s_axi_bresp, s_axi_rresp;
  logic              s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic              tx_valid, pc_sof, pc_ok, pc_fail, rx_store, rx_fifo;
  ctbf_txf_t         tx_frame;
  ctbf_rx_t          rx_in = '0;
  logic [7:0]        lat = 8'h04;   // Frame length in cycles
  logic [65:0]       regq[$], rn;   // Read notes: mask, resp, value
  logic [33:0]       txq[$];        // Frame notes: buffer, payload
  logic [1:0]        rxq[$];        // Receive notes: stored, fifo
  logic [31:0]       d[NBUF];
  int                ord[4] = '{2, 0, 1, 3};
  int                num_errors = 0, n_compared = 0, cyc = 0;

  initial forever #10 sys_clk = ~sys_clk;

  ctbf_core dut (.sys_clk, .reset, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr,
    .s_axi_awprot(3'h0), .s_axi_wvalid, .s_axi_wready, .s_axi_wdata, .s_axi_wstrb(4'hf),
    .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid, .s_axi_arready,
    .s_axi_araddr, .s_axi_arprot(3'h0), .s_axi_rvalid, .s_axi_rready, .s_axi_rdata,
    .s_axi_rresp, .tx_valid, .tx_frame, .pc_sof, .pc_ok, .pc_fail, .rx_in, .rx_store,
    .rx_fifo);
  ctbf_bus_model fab (.sys_clk, .reset, .tx_valid, .fail_all, .lat, .pc_sof, .pc_ok,
    .pc_fail);

  // ==========================================================
  // Tasks
  task automatic cmp(input string nm, input logic [65:0] e, input logic [65:0] g);
    n_compared++;
    if (g !== e) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic conclude();
    $display("compared %0d errors %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // Write: address and data offered together, each dropped once taken
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    do begin
      @(posedge sys_clk);
      if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
    @(posedge sys_clk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m,
                    input logic [1:0] rs = RESP_OKAY);
    regq.push_back({m, rs, e});
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    do begin
      @(posedge sys_clk);
      if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
    @(posedge sys_clk);
  endtask
  // One received frame; released lines carry inverted values
  task automatic rxc(input logic e, input logic [EID_W-1:0] id, input logic s, input logic f);
    rxq.push_back({s, f});
    rx_in <= {1'b1, e, id};
    @(posedge sys_clk);
    rx_in <= {1'b0, ~e, ~id};
    repeat (2) @(posedge sys_clk);
  endtask
  task automatic wait_idle();
    while (txq.size() != 0) @(posedge sys_clk);
    repeat (4) @(posedge sys_clk);
  endtask

  // ==========================================================
  // Monitor: takes the oldest note whenever a result shows
  always @(posedge sys_clk) begin
    pv <= rx_in.valid;
    if (pv === 1'b1) cmp("rx", rxq.pop_front(), {rx_store, rx_store & rx_fifo});
    if (s_axi_rvalid === 1'b1 && s_axi_rready === 1'b1) begin
      rn = regq.pop_front();
      cmp("reg", rn[33:0], {s_axi_rresp, s_axi_rdata & rn[65:34]});
    end
    if (pc_ok === 1'b1) cmp("frame", txq.pop_front(), {tx_frame.bufn, tx_frame.data});
    cyc++;
    if (cyc == 20000) begin
      num_errors++;
      conclude();
    end
  end

  // ==========================================================
  // Main sequence
  initial begin
    void'($urandom(11));
    repeat (10) @(posedge sys_clk);
    reset <= 1'b0;
    @(posedge sys_clk);
    rd(OFS_STAT, 32'h200, '1);
    rd(8'hfc, 32'h0, '1, RESP_SLVERR);
    // Global rule only
    wr(OFS_CTRL, 32'h08);
    rxc(1'b0, 29'($urandom & 32'h7ff), 1'b1, 1'b0);
    rxc(1'b1, 29'($urandom), 1'b1, 1'b1);
    wr(OFS_CTRL, 32'h12);
    rxc(1'b0, 29'($urandom & 32'h7ff), 1'b1, 1'b1);
    rxc(1'b1, 29'($urandom), 1'b0, 1'b0);
    // Standard element, zero mask then partial mask
    wr(OFS_SFLT, 32'h9000_0000 | ($urandom & 32'h7ff));
    wr(OFS_CTRL, 32'h24);
    rxc(1'b0, 29'($urandom & 32'h7ff), 1'b1, 1'b1);
    wr(OFS_SFLT, 32'h8ffe_0123);
    rxc(1'b0, 29'h122, 1'b1, 1'b0);
    rxc(1'b0, 29'h023, 1'b0, 1'b0);
    // Extended element, zero mask, both fifos
    wr(OFS_EFA, 32'h2000_0000 | ($urandom & 32'h1fff_ffff));
    wr(OFS_EFB, 32'h8000_0000);
    wr(OFS_CTRL, 32'h50);
    rxc(1'b1, 29'($urandom), 1'b1, 1'b0);
    wr(OFS_EFA, 32'h4000_0000);
    rxc(1'b1, 29'($urandom), 1'b1, 1'b1);
    // Priority element beside the global extended rule
    wr(OFS_SFLT, 32'ha000_0000);
    wr(OFS_CTRL, 32'h20);
    rxc(1'b0, 29'h5, 1'b0, 1'b0);
    rd(OFS_STAT, 32'h1, 32'h1);
    wr(OFS_STAT, 32'h1);
    rxc(1'b1, 29'($urandom), 1'b1, 1'b0);
    rd(OFS_STAT, 32'h0, 32'h1);
    // Same-ID group behind a lower ID, one add write
    lat <= 8'h1e;
    for (int i = 0; i < NBUF; i++) begin
      d[i] = $urandom;
      wr(OFS_ID0 + 8'(4 * i), (i == 2) ? 32'h3 : 32'h5);
      wr(OFS_DAT0 + 8'(4 * i), d[i]);
    end
    foreach (ord[k]) txq.push_back({2'(ord[k]), d[ord[k]]});
    wr(OFS_ADD, 32'hf);
    rd(OFS_STAT, 32'h300, 32'h300);
    wait_idle();
    rd(OFS_OCC, 32'hf, '1);
    rd(OFS_STAT, 32'h200, 32'h300);
    // Retransmission disabled: a failure retires the buffer
    wr(OFS_CTRL, 32'h21);
    fail_all <= 1'b1;
    wr(OFS_ADD, 32'h1);
    while (pc_fail !== 1'b1) @(posedge sys_clk);
    repeat (6) @(posedge sys_clk);
    rd(OFS_ADD, 32'h0, 32'h1);
    rd(OFS_CFIN, 32'h1, 32'h1);
    // Retry, cancel and overwrite while the retry is on the bus
    wr(OFS_CTRL, 32'h20);
    wr(OFS_ADD, 32'h2);
    while (pc_fail !== 1'b1) @(posedge sys_clk);
    fail_all <= 1'b0;
    while (pc_sof !== 1'b1) @(posedge sys_clk);
    txq.push_back({2'h1, d[1]});
    wr(OFS_CAN, 32'h2);
    wr(OFS_DAT0 + 8'h04, $urandom);
    wait_idle();
    rd(OFS_OCC, 32'h2, 32'h2);
    rd(OFS_CFIN, 32'h0, 32'h2);
    rd(OFS_ADD, 32'h0, 32'h2);
    conclude();
  end
endmodule // test_can_tx_buffer_and_id_filter
